// ==== design/legacy_decode_pkg.sv ====
// constants, types and register map of the legacy address decoder
package legacy_decode_pkg;
  // ==========================================================================
  // widths
  localparam int ADDR_W = 40;
  localparam int FSB_ADDR_W = 36;
  localparam int SEG_COUNT = 13;
  localparam int PORT_COUNT = 4;
  localparam int PORT_IDX_W = 2;
  localparam int REG_ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEG_IDX_W = 4;
  localparam int SEG_SHIFT = 14;
  localparam int LOW32_W = 32;
  // ==========================================================================
  // register offsets and field positions
  localparam logic [REG_ADDR_W-1:0] SEG_ATTR_OFS = 8'h00;
  localparam logic [REG_ADDR_W-1:0] VIDEO_CTRL_OFS = 8'h04;
  localparam logic [REG_ADDR_W-1:0] ROUTE_STAT_OFS = 8'h08;
  localparam int SMM_EN_BIT = 16;
  localparam int STAT_PORT_LSB = 2;
  localparam int STAT_FMT_BIT = 4;
  localparam int STAT_UC_BIT = 5;
  localparam int STAT_VALID_BIT = 6;
  // ==========================================================================
  // reset values
  localparam logic [2*SEG_COUNT-1:0] SEG_ATTR_RST = 26'h0000000;
  localparam logic [PORT_COUNT-1:0] VIDEO_EN_RST = 4'h0;
  // ==========================================================================
  // region bounds below 1 MB
  localparam logic [ADDR_W-1:0] VIDEO_BASE = 40'h00000A0000;
  localparam logic [ADDR_W-1:0] SEG_BASE = 40'h00000C0000;
  localparam logic [ADDR_W-1:0] UPPER_BIOS_BASE = 40'h00000F0000;
  localparam logic [ADDR_W-1:0] ONE_MB = 40'h0000100000;
  localparam logic [SEG_IDX_W-1:0] UPPER_BIOS_IDX = 4'hC;
  // ==========================================================================
  // segment attribute encodings: bit 0 reads to DRAM, bit 1 writes to DRAM
  localparam logic [1:0] ATTR_SOUTH = 2'h0;
  localparam logic [1:0] ATTR_READ_DRAM = 2'h1;
  localparam logic [1:0] ATTR_WRITE_DRAM = 2'h2;
  localparam logic [1:0] ATTR_BOTH_DRAM = 2'h3;
  localparam int ATTR_READ_BIT = 0;
  localparam int ATTR_WRITE_BIT = 1;
  // ==========================================================================
  // types
  typedef enum logic [1:0] {TGT_DRAM, TGT_SOUTH, TGT_PORT} target_type;
  typedef enum logic [1:0] {SRC_FSB, SRC_GFX, SRC_SOUTH} source_type;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    source_type source;
  } request_type;
  typedef struct packed {
    logic valid;
    target_type target;
    logic [PORT_IDX_W-1:0] port;
    logic fmt64;
    logic uncacheable;
    logic [ADDR_W-1:0] addr;
  } route_type;
endpackage

// ==== design/legacy_address_decoder.sv ====
// address decoder for the region below 1 MB of the memory hub
// Behaviour
// - carry 40-bit addresses, 36 from processors
// - 32-bit format unless upper bits nonzero
// - lowest 640 KB always to DRAM
// - video window to south link after reset
// - video window to port with route enable
// - hub-internal targets decoded before external ports
// - video window always uncacheable
// - management flag picks DRAM over video port
// - management flag sampled with request strobe
// - non-management processor requests go to video
// - graphics and south requests never reach DRAM in the video window
// - thirteen segments, independent read/write attributes
// - expansion segments four states, split destinations
// - disabled segments go to south link
// - DRAM below 1 MB never remapped
// - attribute codes select per-direction destination
// - segment attributes reset to south link
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module legacy_address_decoder
  import legacy_decode_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // request side
  input wire logic request_strobe_i,
  input wire request_type request_i,
  input wire logic request_addr_bit7_i,
  // routing decision
  output route_type route_o
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [2*SEG_COUNT-1:0] seg_attr;
    logic [PORT_COUNT-1:0] video_route_enable;
    logic smm_enable;
    logic [DATA_W-1:0] rdata;
    route_type route;
  } state_type;

  state_type state_q;
  state_type state_d;

  // lowest set video enable wins; software keeps at most one set
  function automatic logic [PORT_IDX_W-1:0] first_port(input logic [PORT_COUNT-1:0] en);
    logic [PORT_IDX_W-1:0] idx;
    idx = '0;
    for (int i = PORT_COUNT - 1; i >= 0; i--) begin
      if (en[i]) begin
        idx = PORT_IDX_W'(i);
      end
    end
    return idx;
  endfunction

  // segment number 0..12 of an address inside C0000h..FFFFFh
  function automatic logic [SEG_IDX_W-1:0] seg_index(input logic [ADDR_W-1:0] a);
    logic [SEG_IDX_W-1:0] idx;
    if (a >= UPPER_BIOS_BASE) begin
      idx = UPPER_BIOS_IDX;
    end else begin
      idx = SEG_IDX_W'((a - SEG_BASE) >> SEG_SHIFT);
    end
    return idx;
  endfunction

  // video window test, shared by the checks below
  function automatic logic in_video(input logic [ADDR_W-1:0] a);
    return a >= VIDEO_BASE && a < SEG_BASE;
  endfunction

  // shadow segment test, C0000h up to the 1 MB boundary
  function automatic logic in_seg(input logic [ADDR_W-1:0] a);
    return a >= SEG_BASE && a < ONE_MB;
  endfunction

  // full decode of one request against the current programming
  function automatic route_type decode(input request_type rq, input logic smm_flag, input state_type s);
    route_type r;
    logic [1:0] attr;
    logic [SEG_IDX_W-1:0] sidx;
    r = '0;
    attr = '0;
    sidx = seg_index(rq.addr);
    r.valid = 1'b1;
    r.addr = rq.addr;
    r.fmt64 = |rq.addr[ADDR_W-1:LOW32_W];
    r.target = TGT_SOUTH;
    if (rq.addr < VIDEO_BASE) begin
      r.target = TGT_DRAM;
    end else if (rq.addr < SEG_BASE) begin
      r.uncacheable = 1'b1;
      // internal SMM decode claims the window before any port is considered
      if (s.smm_enable && rq.source == SRC_FSB && smm_flag) begin
        r.target = TGT_DRAM;
      end else if (|s.video_route_enable) begin
        r.target = TGT_PORT;
        r.port = first_port(s.video_route_enable);
      end else begin
        r.target = TGT_SOUTH;
      end
    end else if (rq.addr < ONE_MB) begin
      attr = s.seg_attr[2*sidx +: 2];
      // disabled directions go out to the south link with the address untouched
      if (rq.write) begin
        r.target = attr[ATTR_WRITE_BIT] ? TGT_DRAM : TGT_SOUTH;
      end else begin
        r.target = attr[ATTR_READ_BIT] ? TGT_DRAM : TGT_SOUTH;
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    state_d = state_q;
    state_d.rdata = '0;
    state_d.route.valid = 1'b0;
    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        SEG_ATTR_OFS: state_d.seg_attr = reg_wdata_i[2*SEG_COUNT-1:0];
        VIDEO_CTRL_OFS: begin
          state_d.video_route_enable = reg_wdata_i[PORT_COUNT-1:0];
          state_d.smm_enable = reg_wdata_i[SMM_EN_BIT];
        end
        default: ;
      endcase
    end
    // register reads, answered in the next cycle only
    if (reg_rd_i) begin
      case (reg_addr_i)
        SEG_ATTR_OFS: state_d.rdata[2*SEG_COUNT-1:0] = state_q.seg_attr;
        VIDEO_CTRL_OFS: begin
          state_d.rdata[PORT_COUNT-1:0] = state_q.video_route_enable;
          state_d.rdata[SMM_EN_BIT] = state_q.smm_enable;
        end
        ROUTE_STAT_OFS: begin
          state_d.rdata[1:0] = state_q.route.target;
          state_d.rdata[STAT_PORT_LSB +: PORT_IDX_W] = state_q.route.port;
          state_d.rdata[STAT_FMT_BIT] = state_q.route.fmt64;
          state_d.rdata[STAT_UC_BIT] = state_q.route.uncacheable;
          state_d.rdata[STAT_VALID_BIT] = state_q.route.valid;
        end
        default: state_d.rdata = '0;
      endcase
    end
    // decode uses programming as it stood before this cycle's write
    if (request_strobe_i) begin
      state_d.route = decode(request_i, request_addr_bit7_i, state_q);
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= '0;
      state_q.seg_attr <= SEG_ATTR_RST;
      state_q.video_route_enable <= VIDEO_EN_RST;
      state_q.route.target <= TGT_SOUTH;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_o = state_q.rdata;
  assign route_o = state_q.route;

  // ==========================================================================
  // checks
  request_type last_req_q;
  logic last_flag_q;
  logic last_stb_q;
  state_type last_state_q;

  // copy of the request and programming seen by the decoder
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      last_req_q <= '0;
      last_flag_q <= 1'b0;
      last_stb_q <= 1'b0;
      last_state_q <= '0;
    end else begin
      last_req_q <= request_i;
      last_flag_q <= request_addr_bit7_i;
      last_stb_q <= request_strobe_i;
      last_state_q <= state_q;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // the low region ignores every attribute
  dos_to_dram_a: assert property (request_strobe_i && request_i.addr < VIDEO_BASE |=>
    route_o.valid && route_o.target == TGT_DRAM) else $error("low region not sent to DRAM");

  // short format whenever the address fits in 32 bits
  addr_format_a: assert property (last_stb_q |-> route_o.fmt64 == (|last_req_q.addr[ADDR_W-1:LOW32_W]))
    else $error("wrong address format");

  // no region below 1 MB is ever relocated
  addr_kept_a: assert property (last_stb_q |-> route_o.addr == last_req_q.addr)
    else $error("address altered");

  // with no port owning video the window leaves through the south link
  video_default_a: assert property (last_stb_q && last_state_q.video_route_enable == '0 &&
    last_req_q.addr >= VIDEO_BASE && last_req_q.addr < SEG_BASE && !(last_state_q.smm_enable && last_flag_q &&
    last_req_q.source == SRC_FSB) |-> route_o.target == TGT_SOUTH) else $error("video not to south link");

  // an enabled port takes the window
  video_port_a: assert property (last_stb_q && last_state_q.video_route_enable != '0 && !last_flag_q &&
    last_req_q.addr >= VIDEO_BASE && last_req_q.addr < SEG_BASE |-> route_o.target == TGT_PORT &&
    last_state_q.video_route_enable[route_o.port]) else $error("video not to enabled port");

  // the window is never cacheable, whoever owns it
  video_uncache_a: assert property (route_o.valid && route_o.addr >= VIDEO_BASE && route_o.addr < SEG_BASE
    |-> route_o.uncacheable) else $error("video window cacheable");

  // management accesses from the processor land in DRAM
  smm_dram_a: assert property (request_strobe_i && state_q.smm_enable && request_addr_bit7_i &&
    request_i.source == SRC_FSB && request_i.addr >= VIDEO_BASE && request_i.addr < SEG_BASE
    |=> route_o.target == TGT_DRAM) else $error("management access not to DRAM");

  // inbound traffic must never see management memory
  io_no_dram_a: assert property (last_stb_q && last_req_q.source != SRC_FSB &&
    last_req_q.addr >= VIDEO_BASE && last_req_q.addr < SEG_BASE |-> route_o.target != TGT_DRAM)
    else $error("inbound access reached DRAM");

  // per-direction attribute bit picks DRAM or the south link
  seg_route_a: assert property (last_stb_q && last_req_q.addr >= SEG_BASE && last_req_q.addr < ONE_MB |->
    (route_o.target == TGT_DRAM) == last_state_q.seg_attr[2*seg_index(last_req_q.addr) +
    (last_req_q.write ? ATTR_WRITE_BIT : ATTR_READ_BIT)]) else $error("segment routed against attribute");

  // after reset every segment points at the south link
  reset_attr_a: assert property ($fell(sys_rst_i) |-> state_q.seg_attr == SEG_ATTR_RST)
    else $error("segment attributes not reset");

  // read data stands for one cycle only, so a stale word is never taken twice
  read_once_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside answer cycle");

  // a decision pulses valid for exactly the cycle after its strobe
  valid_pulse_a: assert property (route_o.valid == last_stb_q)
    else $error("route valid not one cycle after strobe");

  // management request claimed internally ahead of an enabled video port
  smm_first_a: assert property (last_stb_q && last_state_q.smm_enable && last_flag_q &&
    last_req_q.source == SRC_FSB && in_video(last_req_q.addr) && last_state_q.video_route_enable != '0
    |-> route_o.target == TGT_DRAM) else $error("internal decode not taken first");

  // processor request outside management mode treated as video buffer access
  non_smm_video_a: assert property (last_stb_q && last_state_q.smm_enable && !last_flag_q &&
    in_video(last_req_q.addr) |-> route_o.target != TGT_DRAM) else $error("non-management access reached DRAM");

  // a disabled direction of a segment leaves through the south link
  seg_disabled_a: assert property (last_stb_q && in_seg(last_req_q.addr) &&
    !last_state_q.seg_attr[2*seg_index(last_req_q.addr) + (last_req_q.write ? ATTR_WRITE_BIT : ATTR_READ_BIT)]
    |-> route_o.target == TGT_SOUTH) else $error("disabled segment not sent south");

  // only the video window is marked uncacheable
  cache_elsewhere_a: assert property (last_stb_q && !in_video(last_req_q.addr) |-> !route_o.uncacheable)
    else $error("uncacheable outside video window");

  // write-only code sends writes to DRAM while reads go elsewhere
  seg_split_a: assert property (last_stb_q && in_seg(last_req_q.addr) && last_req_q.write &&
    last_state_q.seg_attr[2*seg_index(last_req_q.addr) +: 2] == ATTR_WRITE_DRAM |-> route_o.target == TGT_DRAM)
    else $error("write-only segment write not to DRAM");

  // upper BIOS segment shares one attribute pair across its 64 KB
  upper_bios_a: assert property (last_stb_q && !last_req_q.write &&
    last_req_q.addr >= UPPER_BIOS_BASE && last_req_q.addr < ONE_MB |->
    (route_o.target == TGT_DRAM) == last_state_q.seg_attr[2*UPPER_BIOS_IDX + ATTR_READ_BIT])
    else $error("upper BIOS read against attribute");

  // processors give 36 address bits; the upper four pass as sent
  wide_addr_a: assert property (last_stb_q && last_req_q.source == SRC_FSB |->
    route_o.addr[ADDR_W-1:FSB_ADDR_W] == last_req_q.addr[ADDR_W-1:FSB_ADDR_W]) else $error("upper address bits lost");

  // reset leaves the video window with the south link
  reset_video_a: assert property ($fell(sys_rst_i) |-> route_o.target == TGT_SOUTH &&
    state_q.video_route_enable == '0) else $error("video routing not reset");

endmodule // legacy_address_decoder
`default_nettype wire

// ==== tb/request_source.sv ====
// request source model standing in for the processor bus side
`timescale 1ns/1ns
`default_nettype none
module request_source
  import legacy_decode_pkg::*;
(
  // clock
  input wire logic clk_i,
  // request side
  output logic request_strobe_o,
  output request_type request_o,
  output logic request_addr_bit7_o
);
  // ========
  // idle lines show the inverse of the last value so a stale copy never decodes by luck
  initial begin
    request_strobe_o = 1'b0;
    request_o = '0;
    request_addr_bit7_o = 1'b0;
  end
  // one-cycle strobe with address and flag held for the whole cycle
  task automatic issue(input request_type r, input logic smm);
    @(posedge clk_i);
    request_strobe_o <= 1'b1;
    request_o <= r;
    request_addr_bit7_o <= smm;
    @(posedge clk_i);
    request_strobe_o <= 1'b0;
    request_o <= request_type'(~r);
    request_addr_bit7_o <= ~smm;
  endtask
endmodule // request_source
`default_nettype wire

// ==== tb/legacy_address_decoder_test.sv ====
// self-checking bench of the legacy address decoder against a reference model
`timescale 1ns/1ns
`default_nettype none
module legacy_address_decoder_test import legacy_decode_pkg::*;;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [REG_ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic request_strobe_i;
  request_type request_i;
  logic request_addr_bit7_i;
  route_type route_o;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [2*SEG_COUNT-1:0] m_seg = '0;
  logic [PORT_COUNT-1:0] m_vid = '0;
  logic m_smm = 1'b0;
  // ========
  // clock, timeout and instances
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end
  legacy_address_decoder DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .request_strobe_i(request_strobe_i), .request_i(request_i),
    .request_addr_bit7_i(request_addr_bit7_i), .route_o(route_o));
  request_source src (.clk_i(clk_i), .request_strobe_o(request_strobe_i), .request_o(request_i),
    .request_addr_bit7_o(request_addr_bit7_i));
  // ========
  // helpers
  task automatic chk(input string what, input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("read data", 40'(exp), 40'(reg_rdata_o));
  endtask
  task automatic cfg(input logic [25:0] s, input logic [3:0] v, input logic e);
    m_seg = s;
    m_vid = v;
    m_smm = e;
    wr(SEG_ATTR_OFS, 32'(s));
    wr(VIDEO_CTRL_OFS, {15'h0000, e, 12'h000, v});
    rd(SEG_ATTR_OFS, 32'(s));
    rd(VIDEO_CTRL_OFS, {15'h0000, e, 12'h000, v});
  endtask
  // reference model: works out the route, then compares every field, the port only for port targets
  task automatic req(input logic [ADDR_W-1:0] a, input logic w, input source_type s, input logic f);
    int tgt;
    int idx;
    int p;
    logic uc;
    request_type r;
    r.addr = a;
    r.write = w;
    r.source = s;
    uc = 1'b0;
    tgt = 1;
    p = 0;
    for (int i = 3; i >= 0; i--) if (m_vid[i]) p = i;
    if (a < VIDEO_BASE) tgt = 0;
    else if (a < SEG_BASE) begin
      uc = 1'b1;
      if (m_smm && f && s == SRC_FSB) tgt = 0;
      else if (m_vid != 4'h0) tgt = 2;
    end else if (a < ONE_MB) begin
      idx = (a >= UPPER_BIOS_BASE) ? 12 : int'((a - SEG_BASE) >> SEG_SHIFT);
      if (m_seg[2*idx + (w ? 1 : 0)]) tgt = 0;
    end
    src.issue(r, f);
    #1 chk("valid", 40'h1, 40'(route_o.valid));
    chk("target", 40'(tgt), 40'(route_o.target));
    chk("uncacheable", 40'(uc), 40'(route_o.uncacheable));
    chk("fmt64", 40'(a[39:32] != 8'h00), 40'(route_o.fmt64));
    chk("addr", a, route_o.addr);
    if (tgt == 2) chk("port", 40'(p), 40'(route_o.port));
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ========
  // main sequence
  initial begin
    logic [ADDR_W-1:0] a;
    void'($urandom(32'h9d1c2940));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(SEG_ATTR_OFS, 32'h00000000);
    rd(VIDEO_CTRL_OFS, 32'h00000000);
    rd(8'h0C, 32'h00000000);
    req(40'h00000A0000, 1'b0, SRC_FSB, 1'b0);
    req(40'h000009FFFF, 1'b1, SRC_GFX, 1'b1);
    $display("test reset defaults done");
    // every attribute code on every segment, both directions
    for (int c = 0; c < 4; c++) begin
      cfg({13{c[1:0]}}, 4'h0, 1'b0);
      for (int g = 0; g < 13; g++) begin
        req(SEG_BASE + 40'(g) * 40'h0000004000 + 40'h10, 1'b0, SRC_FSB, 1'b0);
        req(SEG_BASE + 40'(g) * 40'h0000004000 + 40'h3FF0, 1'b1, SRC_SOUTH, 1'b0);
      end
    end
    $display("test segment attributes done");
    cfg(26'h0000000, 4'h4, 1'b1);
    req(40'h00000B0000, 1'b0, SRC_FSB, 1'b1);
    req(40'h00000B0000, 1'b0, SRC_FSB, 1'b0);
    rd(ROUTE_STAT_OFS, 32'(TGT_PORT) | (32'h2 << STAT_PORT_LSB) | (32'h1 << STAT_UC_BIT));
    req(40'h00000A0000, 1'b1, SRC_GFX, 1'b1);
    req(40'h00000BFFFF, 1'b0, SRC_SOUTH, 1'b1);
    $display("test management overlay done");
    for (int n = 0; n < 300; n++) begin
      // at most one video owner; alias and I/O window duties live in ports beyond this block
      if (n % 20 == 0) cfg(26'($urandom), ($urandom_range(0, 4) == 4) ? 4'h0 : 4'(1 << $urandom_range(0, 3)),
        1'($urandom));
      a = 40'($urandom_range(0, 32'h000FFFFF));
      if ($urandom_range(0, 7) == 0) a[39:32] = 8'($urandom);
      req(a, 1'($urandom), source_type'($urandom_range(0, 2)), 1'($urandom));
    end
    $display("test random traffic done");
    finish_test();
  end
endmodule // legacy_address_decoder_test
`default_nettype wire
